/* core/rbs_defines.svh */
// Functional notes
// - watchdog free-runs, clear restarts, timeout resets
// - watchdog reset held two machine cycles
// - watchdog flag survives resets except power-on
// - writing chip control bit 7 starts reset
// - trigger bit write-only, self-clears after reset
// - software reset sets its flag, sticky
// - boot select write picks next boot block
// - boot select read shows current boot block
// - non-software resets load inverted config bit 7
// - config bit one means application block
// - release uses boot select, not config
// - reset never touches on-chip RAM
// - program counter held 0000H during reset
// - reset sets stack pointer to 07H
// - reset disables interrupts, timers; ports FFH
// - other registers return to initial values, except config and the reset flags
// - power-on sets power flag, sticky otherwise
// - brown-out flag sticky except power-on
`ifndef RBS_DEFINES_SVH
`define RBS_DEFINES_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define RBS_ADDR_RSTAT 8'h96
`define RBS_ADDR_PWR 8'h87
`define RBS_ADDR_CHIP 8'h9F
`define RBS_ADDR_KEY 8'hC7
`define RBS_ADDR_WDOG 8'hAA
`define RBS_ADDR_CFG 8'hF0
// ----------------------------------------
// field positions
// ----------------------------------------
`define RBS_CHIP_TRIG 7
`define RBS_CHIP_BOOT 1
`define RBS_WDOG_EN 7
`define RBS_WDOG_CLR 6
`define RBS_WDOG_FLAG 3
`define RBS_RSTAT_BOR 2
`define RBS_RSTAT_SW 0
`define RBS_PWR_FLAG 4
`define RBS_CFG_BOOT 7
// ----------------------------------------
// values and timing
// ----------------------------------------
`define RBS_KEY_FIRST 8'hAA
`define RBS_KEY_SECOND 8'h55
`define RBS_CFG_RESET 8'hFF
`define RBS_CHIP_MASK 8'h73
`define RBS_PC_RESET 16'h0000
`define RBS_SP_RESET 8'h07
`define RBS_PORT_RESET 8'hFF
`define RBS_CLK_PER_MC 12
`define RBS_HOLD_MC 2
`define RBS_WDOG_BASE 2048
`endif

/* core/rbs_pkg.sv */
package rbs_pkg;
   typedef enum logic [1:0] {
      RBS_RUN = 2'b00,
      RBS_HOLD = 2'b01,
      RBS_WAIT = 2'b10
   } rbs_state_type;
   typedef enum logic [1:0] {
      RBS_KEY_IDLE = 2'b00,
      RBS_KEY_HALF = 2'b01,
      RBS_KEY_OPEN = 2'b10
   } rbs_key_type;
endpackage

/* core/rbs_sync_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface rbs_sync_if;
   logic raw;
   logic level;
   logic rise;
   modport src (output raw, input level, rise);
   modport dst (input raw, output level, rise);
endinterface
`default_nettype wire

/* core/rbs_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module rbs_pin_sync (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // pin
   rbs_sync_if.dst sp
);
   logic [2:0] sh_r;
   logic [2:0] sh_nxt;
   logic lvl_r;
   logic lvl_nxt;
   logic rise_r;
   logic rise_nxt;
   // ----------------------------------------
   // three flops, second and third must agree
   // ----------------------------------------
   always_comb begin
      sh_nxt = {sh_r[1:0], sp.raw};
      lvl_nxt = lvl_r;
      if (sh_r[1] == sh_r[2]) begin
         lvl_nxt = sh_r[2];
      end
      rise_nxt = lvl_nxt & ~lvl_r;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_r <= 3'h0;
         lvl_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         sh_r <= sh_nxt;
         lvl_r <= lvl_nxt;
         rise_r <= rise_nxt;
      end
   end
   assign sp.level = lvl_r;
   assign sp.rise = rise_r;
endmodule
`default_nettype wire

/* core/rbs_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rbs_defines.svh"
module rbs_top #(
   parameter int WDOG_BASE = `RBS_WDOG_BASE,
   parameter int CLK_PER_MC = `RBS_CLK_PER_MC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // other reset sources, from pins
   input wire logic power_on_rst,
   input wire logic brownout_rst,
   input wire logic pin_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // system reset outputs
   output logic sys_rst,
   output logic [15:0] pc_value,
   output logic [7:0] sp_value,
   output logic [7:0] port_out,
   output logic irq_timer_en,
   output logic boot_loader
);
   import rbs_pkg::*;
   // counters are 4 and 21 bits wide, larger values cannot be served
   localparam bit BAD_PARAM = (WDOG_BASE < 2) || (WDOG_BASE > 16383) ||
      (CLK_PER_MC < 1) || (CLK_PER_MC > 16);
   if (BAD_PARAM) begin : g_bad_param
      $error("rbs_top: bad parameter");
   end
   localparam int HOLD_CYC = `RBS_HOLD_MC * CLK_PER_MC;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   rbs_sync_if por_if ();
   rbs_sync_if bor_if ();
   rbs_sync_if pin_if ();
   assign por_if.raw = power_on_rst;
   assign bor_if.raw = brownout_rst;
   assign pin_if.raw = pin_rst;
   rbs_pin_sync u_por (.ref_clk(ref_clk), .rst_n(rst_n), .sp(por_if));
   rbs_pin_sync u_bor (.ref_clk(ref_clk), .rst_n(rst_n), .sp(bor_if));
   rbs_pin_sync u_pin (.ref_clk(ref_clk), .rst_n(rst_n), .sp(pin_if));
   // ----------------------------------------
   // state
   // ----------------------------------------
   rbs_state_type st_r;
   rbs_state_type st_nxt;
   rbs_key_type key_r;
   rbs_key_type key_nxt;
   logic [15:0] hold_r;
   logic [15:0] hold_nxt;
   logic [3:0] mc_r;
   logic [3:0] mc_nxt;
   logic [20:0] wd_r;
   logic [20:0] wd_nxt;
   logic wd_en_r;
   logic wd_en_nxt;
   logic [2:0] wd_ps_r;
   logic [2:0] wd_ps_nxt;
   // cause flags survive warm resets; power-on clears them all but power_on_flag_r, which it sets
   logic wdf_r;
   logic wdf_nxt;
   logic swf_r;
   logic swf_nxt;
   logic brownout_flag_r;
   logic brownout_flag_nxt;
   logic power_on_flag_r;
   logic power_on_flag_nxt;
   // written select for the next boot, apart from the block booted last
   logic boot_sel_r;
   logic boot_sel_nxt;
   logic boot_r;
   logic boot_nxt;
   logic [7:0] chip_r;
   logic [7:0] chip_nxt;
   logic trig_r;
   logic trig_nxt;
   logic sw_cause_r;
   logic sw_cause_nxt;
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;
   logic [7:0] rdata_nxt;
   logic mc_tick;
   logic wd_expire;
   logic ext_rst;
   logic any_start;
   logic [20:0] wd_limit;
   assign mc_tick = (mc_r == 4'(CLK_PER_MC - 1));
   assign wd_limit = 21'(WDOG_BASE) << wd_ps_r;
   assign ext_rst = por_if.level | bor_if.level | pin_if.level;
   always_comb begin
      st_nxt = st_r;
      key_nxt = key_r;
      hold_nxt = hold_r;
      mc_nxt = mc_tick ? 4'h0 : mc_r + 4'h1;
      wd_nxt = wd_r;
      wd_en_nxt = wd_en_r;
      wd_ps_nxt = wd_ps_r;
      wdf_nxt = wdf_r;
      swf_nxt = swf_r;
      brownout_flag_nxt = brownout_flag_r;
      power_on_flag_nxt = power_on_flag_r;
      boot_sel_nxt = boot_sel_r;
      boot_nxt = boot_r;
      chip_nxt = chip_r;
      trig_nxt = trig_r;
      sw_cause_nxt = sw_cause_r;
      cfg_nxt = cfg_r;
      rdata_nxt = 8'h00;
      wd_expire = 1'b0;
      any_start = 1'b0;
      // watchdog counts machine cycles
      if (st_r == RBS_RUN && wd_en_r && mc_tick) begin
         if (wd_r + 21'h1 >= wd_limit) begin
            wd_expire = 1'b1;
         end else begin
            wd_nxt = wd_r + 21'h1;
         end
      end
      // ----------------------------------------
      // register writes
      // ----------------------------------------
      if (reg_wr && st_r == RBS_RUN) begin
         if (reg_addr == `RBS_ADDR_KEY) begin
            if (reg_wdata == `RBS_KEY_FIRST) begin
               key_nxt = RBS_KEY_HALF;
            end else if (reg_wdata == `RBS_KEY_SECOND && key_r == RBS_KEY_HALF) begin
               key_nxt = RBS_KEY_OPEN;
            end else begin
               key_nxt = RBS_KEY_IDLE;
            end
         end else begin
            key_nxt = RBS_KEY_IDLE; // one write per unlock
         end
         case (reg_addr)
            `RBS_ADDR_CHIP: begin
               if (key_r == RBS_KEY_OPEN) begin
                  chip_nxt = reg_wdata & `RBS_CHIP_MASK;
                  boot_sel_nxt = reg_wdata[`RBS_CHIP_BOOT];
                  if (reg_wdata[`RBS_CHIP_TRIG]) begin
                     trig_nxt = 1'b1;
                  end
               end
            end
            `RBS_ADDR_WDOG: begin
               if (key_r == RBS_KEY_OPEN) begin
                  wd_en_nxt = reg_wdata[`RBS_WDOG_EN];
                  wd_ps_nxt = reg_wdata[2:0];
                  if (reg_wdata[`RBS_WDOG_CLR]) begin
                     wd_nxt = 21'h0;
                  end
                  if (!reg_wdata[`RBS_WDOG_FLAG]) begin
                     wdf_nxt = 1'b0;
                  end
               end
            end
            `RBS_ADDR_RSTAT: begin
               if (!reg_wdata[`RBS_RSTAT_BOR]) begin
                  brownout_flag_nxt = 1'b0;
               end
               if (!reg_wdata[`RBS_RSTAT_SW]) begin
                  swf_nxt = 1'b0;
               end
            end
            `RBS_ADDR_PWR: begin
               if (!reg_wdata[`RBS_PWR_FLAG]) begin
                  power_on_flag_nxt = 1'b0;
               end
            end
            `RBS_ADDR_CFG: begin
               cfg_nxt = reg_wdata;
            end
            default: begin
            end
         endcase
      end
      // ----------------------------------------
      // register reads
      // ----------------------------------------
      if (reg_rd) begin
         case (reg_addr)
            `RBS_ADDR_CHIP: rdata_nxt = {1'b0, chip_r[6:2], boot_r, chip_r[0]};
            `RBS_ADDR_WDOG: rdata_nxt = {wd_en_r, 3'h0, wdf_r, wd_ps_r};
            `RBS_ADDR_RSTAT: rdata_nxt = {5'h00, brownout_flag_r, 1'b0, swf_r};
            `RBS_ADDR_PWR: rdata_nxt = {3'h0, power_on_flag_r, 4'h0};
            `RBS_ADDR_CFG: rdata_nxt = cfg_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
      // ----------------------------------------
      // reset sequencer
      // ----------------------------------------
      case (st_r)
         RBS_RUN: begin
            any_start = wd_expire | trig_r | ext_rst;
            if (any_start) begin
               st_nxt = RBS_HOLD;
               hold_nxt = 16'(HOLD_CYC - 1);
               sw_cause_nxt = trig_r & ~wd_expire & ~ext_rst;
               if (wd_expire) begin
                  wdf_nxt = 1'b1;
               end
               if (por_if.level) begin
                  power_on_flag_nxt = 1'b1;
                  wdf_nxt = 1'b0;
                  swf_nxt = 1'b0;
                  brownout_flag_nxt = 1'b0;
               end else if (bor_if.level) begin
                  brownout_flag_nxt = 1'b1;
               end
            end
         end
         RBS_HOLD: begin
            if (hold_r != 16'h0) begin
               hold_nxt = hold_r - 16'h1;
            end else if (ext_rst) begin
               st_nxt = RBS_HOLD; // held while a pin is high
            end else begin
               st_nxt = RBS_WAIT;
            end
         end
         RBS_WAIT: begin
            st_nxt = RBS_RUN;
            trig_nxt = 1'b0;
            if (sw_cause_r) begin
               swf_nxt = 1'b1;
            end else begin
               boot_sel_nxt = ~cfg_r[`RBS_CFG_BOOT];
            end
            // boot from the select bit, never straight from config
            boot_nxt = boot_sel_nxt;
            // other control back to initial values
            chip_nxt = 8'h00;
            key_nxt = RBS_KEY_IDLE;
            wd_nxt = 21'h0;
            wd_en_nxt = 1'b0;
            wd_ps_nxt = 3'h0;
         end
         default: st_nxt = RBS_RUN;
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         // power-on default; ram is never cleared here
         st_r <= RBS_WAIT;
         key_r <= RBS_KEY_IDLE;
         hold_r <= 16'h0;
         mc_r <= 4'h0;
         wd_r <= 21'h0;
         wd_en_r <= 1'b0;
         wd_ps_r <= 3'h0;
         wdf_r <= 1'b0;
         swf_r <= 1'b0;
         brownout_flag_r <= 1'b0;
         power_on_flag_r <= 1'b1;
         boot_sel_r <= 1'b0;
         boot_r <= 1'b0;
         chip_r <= 8'h00;
         trig_r <= 1'b0;
         sw_cause_r <= 1'b0;
         cfg_r <= `RBS_CFG_RESET;
         reg_rdata <= 8'h00;
         sys_rst <= 1'b1;
         pc_value <= `RBS_PC_RESET;
         sp_value <= `RBS_SP_RESET;
         port_out <= `RBS_PORT_RESET;
         irq_timer_en <= 1'b0;
         boot_loader <= 1'b0;
      end else begin
         st_r <= st_nxt;
         key_r <= key_nxt;
         hold_r <= hold_nxt;
         mc_r <= mc_nxt;
         wd_r <= wd_nxt;
         wd_en_r <= wd_en_nxt;
         wd_ps_r <= wd_ps_nxt;
         wdf_r <= wdf_nxt;
         swf_r <= swf_nxt;
         brownout_flag_r <= brownout_flag_nxt;
         power_on_flag_r <= power_on_flag_nxt;
         boot_sel_r <= boot_sel_nxt;
         boot_r <= boot_nxt;
         chip_r <= chip_nxt;
         trig_r <= trig_nxt;
         sw_cause_r <= sw_cause_nxt;
         cfg_r <= cfg_nxt;
         reg_rdata <= rdata_nxt;
         sys_rst <= (st_nxt != RBS_RUN);
         // cpu state presets while reset applies
         if (st_nxt != RBS_RUN) begin
            pc_value <= `RBS_PC_RESET;
            sp_value <= `RBS_SP_RESET;
            port_out <= `RBS_PORT_RESET;
            irq_timer_en <= 1'b0;
         end else begin
            irq_timer_en <= 1'b1;
         end
         boot_loader <= boot_nxt;
      end
   end
endmodule
`default_nettype wire

/* dv/rbs_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module rbs_top_sva import rbs_pkg::*; #(
   parameter int CLK_PER_MC = 12
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // reset outputs
   input wire logic sys_rst,
   input wire logic [15:0] pc_value,
   input wire logic [7:0] sp_value,
   input wire logic [7:0] port_out,
   input wire logic irq_timer_en,
   input wire logic boot_loader
);
   // saturates so a long pin reset never wraps
   logic [7:0] hold_r, hold_nxt;
   always_comb begin
      hold_nxt = sys_rst ? ((hold_r == 8'hFF) ? hold_r : hold_r + 8'h01) : 8'h00;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) hold_r <= 8'hFF;
      else hold_r <= hold_nxt;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence key_open;
      reg_wr && reg_addr == 8'hC7 && reg_wdata == 8'hAA
      ##1 reg_wr && reg_addr == 8'hC7 && reg_wdata == 8'h55;
   endsequence
   chk_pc_held: assert property (sys_rst && $past(sys_rst) |-> pc_value == 16'h0000)
      else $error("pc not zero in reset");
   chk_sp_reset: assert property (sys_rst && $past(sys_rst) |-> sp_value == 8'h07)
      else $error("sp not 07 in reset");
   chk_port_high: assert property (sys_rst && $past(sys_rst) |-> port_out == 8'hFF)
      else $error("port not FF in reset");
   chk_irq_run: assert property (sys_rst |-> !irq_timer_en)
      else $error("irq enabled in reset");
   chk_hold_len: assert property ($fell(sys_rst) |-> hold_r >= 8'(2 * CLK_PER_MC))
      else $error("reset held too short");
   chk_soft_trig: assert property (
      key_open ##1 (reg_wr && reg_addr == 8'h9F && reg_wdata[7] && !sys_rst) |-> ##[1:4] sys_rst)
      else $error("soft reset did not start");
   chk_boot_write: assert property (
      key_open ##1 (reg_wr && reg_addr == 8'h9F && !reg_wdata[7] && !sys_rst)
      |=> $stable(boot_loader))
      else $error("boot select applied before reboot");
   chk_boot_steady: assert property (!sys_rst && !$past(sys_rst) |-> $stable(boot_loader))
      else $error("boot block changed outside reset");
   chk_boot_read: assert property (reg_rd && reg_addr == 8'h9F && !sys_rst
      |=> reg_rdata[1] == $past(boot_loader))
      else $error("boot select read wrong");
   chk_trig_wo: assert property (reg_rd && reg_addr == 8'h9F |=> !reg_rdata[7])
      else $error("trigger bit read back");
   cover property ($rose(sys_rst));
   cover property ($fell(sys_rst));
   cover property (reg_rd && reg_addr == 8'h9F);
endmodule
bind rbs_top rbs_top_sva #(.CLK_PER_MC(CLK_PER_MC)) u_sva (.ref_clk, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_rst, .pc_value, .sp_value, .port_out,
   .irq_timer_en, .boot_loader);
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import rbs_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic power_on_rst = 1'b0, brownout_rst = 1'b0, pin_rst = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, sys_rst, irq_timer_en, boot_loader;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, sp_value, port_out;
   logic [15:0] pc_value;
   int num_errors = 0, checks_done = 0, cycles = 0;
   localparam int MC = 2;
   // rows: address, mask, expected read
   logic [23:0] rows [6] = '{24'h87FF10, 24'h96FF00, 24'hAA0800, 24'hF0FFFF,
      24'h9F8200, 24'h55FF00};
   // short counts keep the run brief
   rbs_top #(.WDOG_BASE(4), .CLK_PER_MC(MC)) DUT (.ref_clk, .rst_n, .power_on_rst,
      .brownout_rst, .pin_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .sys_rst, .pc_value, .sp_value, .port_out, .irq_timer_en, .boot_loader);
   initial forever #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
   endtask
   task automatic idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk({8'h00, reg_rdata & m}, {8'h00, e});
      @(posedge ref_clk);
   endtask
   // key pair then the guarded write
   task automatic kwr(input logic [7:0] a, input logic [7:0] d);
      wr(8'hC7, 8'hAA);
      wr(8'hC7, 8'h55);
      wr(a, d);
      idle();
   endtask
   // wait for a reset to come and go
   task automatic ride();
      int n;
      int h;
      n = 0;
      h = 0;
      while (sys_rst !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      while (sys_rst !== 1'b0 && h < 200) begin
         @(posedge ref_clk);
         h++;
      end
      // reset must come, last at least two machine cycles, and end
      chk(16'(n < 100 && h >= 2 * MC && h < 200), 16'h0001);
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(pc_value, 16'h0000);
      chk({sp_value, port_out}, 16'h07FF);
      chk({14'h0, sys_rst, irq_timer_en}, 16'h0002);
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk({14'h0, sys_rst, irq_timer_en}, 16'h0001);
      for (int i = 0; i < 6; i++) rd(rows[i][23:16], rows[i][15:8], rows[i][7:0]);
      chk({15'h0, boot_loader}, 16'h0000);
      wr(8'h87, 8'h00);
      idle();
      rd(8'h87, 8'hFF, 8'h00);
      wr(8'h9F, 8'h80);
      idle();
      repeat (6) @(posedge ref_clk);
      chk({15'h0, sys_rst}, 16'h0000);
      kwr(8'h9F, 8'h02);
      chk({15'h0, boot_loader}, 16'h0000);
      rd(8'h9F, 8'h82, 8'h00);
      kwr(8'h9F, 8'h82);
      ride();
      chk({15'h0, boot_loader}, 16'h0001);
      rd(8'h96, 8'hFF, 8'h01);
      rd(8'h9F, 8'h82, 8'h02);
      rd(8'h87, 8'hFF, 8'h00);
      pin_rst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      pin_rst <= 1'b0;
      ride();
      chk({15'h0, boot_loader}, 16'h0000);
      wr(8'hF0, 8'h7F);
      idle();
      brownout_rst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      brownout_rst <= 1'b0;
      ride();
      chk({15'h0, boot_loader}, 16'h0001);
      rd(8'h96, 8'hFF, 8'h05);
      wr(8'h96, 8'h04);
      repeat (5) kwr(8'hAA, 8'hC0);
      chk({15'h0, sys_rst}, 16'h0000);
      ride();
      kwr(8'hAA, 8'h08);
      rd(8'hAA, 8'h88, 8'h08);
      rd(8'h96, 8'h05, 8'h04);
      power_on_rst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      power_on_rst <= 1'b0;
      ride();
      rd(8'h87, 8'hFF, 8'h10);
      rd(8'h96, 8'h05, 8'h00);
      rd(8'hAA, 8'h08, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
